// ---- rtl/dpp_pkg.sv ----
// package: offsets, field positions, reset values and codes of the debug port pin block
package dpp_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_PORTCTRL = 8'h00;
    localparam logic [7:0] OFF_CFG0     = 8'h04;
    localparam logic [7:0] OFF_STATUS   = 8'h08;
    localparam logic [7:0] OFF_MASK     = 8'h0c;
    localparam logic [7:0] OFF_SESSION  = 8'h10;
    // field positions
    localparam int BIT_SCAN_EN  = 3;
    localparam int BIT_TRACE_EN = 2;
    localparam int BIT_PAIR_SEL = 3;
    localparam int BIT_DBG_LO   = 0;
    // reset values
    localparam logic SCAN_EN_RST  = 1'b1;
    localparam logic TRACE_EN_RST = 1'b0;
    localparam logic PAIR_SEL_RST = 1'b1;
    localparam logic [1:0] DBG_RST = 2'h3;
    localparam logic [1:0] DBG_OFF = 2'h3;
    // status / mask bits
    localparam int NUM_EVT     = 4;
    localparam int EVT_WDT_ERASE = 0;
    localparam int EVT_PROG_ABORT = 1;
    localparam int EVT_SER_EXIT = 2;
    localparam int EVT_DBG_EXIT = 3;
    // scan instruction codes
    localparam logic [4:0] CMD_SEL_VENDOR = 5'h04;
    localparam logic [4:0] CMD_SEL_EXT    = 5'h05;
    // trace
    localparam logic [3:0] TRACE_FLOW_CODE = 4'hf;
    localparam int TRACE_DIV = 2;
    // pad indices
    localparam int NUM_PADS   = 13;
    localparam int PAD_PDATA1 = 0;
    localparam int PAD_PDATA2 = 1;
    localparam int PAD_SDO    = 2;
    localparam int PAD_TCLK   = 3;
    localparam int PAD_TD0    = 4;
    localparam int PAD_PCLK1  = 8;
    localparam int PAD_PCLK2  = 9;
    localparam int PAD_SCK    = 10;
    localparam int PAD_SDI    = 11;
    localparam int PAD_SMS    = 12;

    typedef enum logic [0:0] {
        TAP_VENDOR = 1'b0,
        TAP_EXT    = 1'b1
    } dpp_tap_type;

    typedef struct packed {
        logic       scanClaim;
        logic       traceClaim;
        logic       progPri;
        logic       progAlt;
    } dpp_claim_type;

    typedef struct packed {
        logic [NUM_PADS-1:0] out;
        logic [NUM_PADS-1:0] oeN;
    } dpp_pads_type;
endpackage

// ---- rtl/dpp_port_select.sv ----
// debug port pin selection, session exit on resets, apb registers
//
// Function
// - master clear assertion during serial programming ends serial programming
// - master clear assertion ends extended debug session
// - watchdog reset never aborts a running chip erase
// - watchdog reset during erase sets the watchdog event flag
// - watchdog reset in extended debug returns to vendor controller
// - watchdog reset during flash programming aborts programming
// - serial programming is entered only through the master clear pin
// - master clear claims the scan port even with scan enable cleared
// - scan pins follow scan port enable bit 3
// - trace pins carry trace only when trace enable bit 2 set
// - primary programming clock chosen by pin pair select bit 3
// - programming data and alternate pins follow pair select and debug field
// - programming and debug session logic ignores interrupts
// - trace reports flow change on interrupt, trace itself unaffected
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module dpp_port_select (
    input  wire logic                         mclk,
    input  wire logic                         reset,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [7:0]                   paddr,
    input  wire logic [31:0]                  pwdata,
    output logic [31:0]                       prdata,
    output logic                              pready,
    output logic                              pslverr,
    output logic                              irq,
    input  wire logic                         masterClearPinN,
    input  wire logic [dpp_pkg::NUM_PADS-1:0] padIn,
    output dpp_pkg::dpp_pads_type             pads,
    input  wire dpp_pkg::dpp_pads_type        altPads,
    output dpp_pkg::dpp_claim_type            claim,
    input  wire logic                         progEnterReq,
    input  wire logic                         progDrive,
    input  wire logic                         progDataOut,
    output logic                              progBitValid,
    output logic                              progBit,
    input  wire logic                         scanDataOut,
    input  wire logic                         instrValid,
    input  wire logic [4:0]                   instrCode,
    output logic                              tapExtended,
    input  wire logic                         watchdogReset,
    input  wire logic                         eraseBusy,
    input  wire logic                         flashProgBusy,
    output logic                              progAbort,
    input  wire logic                         interruptTaken,
    input  wire logic [3:0]                   traceWord,
    output logic                              traceFlowMark
);
    localparam int NP = dpp_pkg::NUM_PADS;
    localparam int NE = dpp_pkg::NUM_EVT;

    logic [1:0]    mclrSync_q;
    logic          mclrOld_q;
    logic [NP-1:0] padSync1_q;
    logic [NP-1:0] padSync2_q;
    logic          pclkOld_q;
    logic          scanEn_q;
    logic          traceEn_q;
    logic          pairSel_q;
    logic [1:0]    dbgCfg_q;
    logic [NE-1:0] status_q;
    logic [NE-1:0] mask_q;
    logic [NE-1:0] evtSet;
    logic [NE-1:0] rdClr;
    logic          serProg_q;
    dpp_pkg::dpp_tap_type tap_q;
    logic [31:0]   prdata_q;
    logic          irq_q;
    logic          progAbort_q;
    logic          progBitValid_q;
    logic          progBit_q;
    logic          traceTick_q;
    logic          tclk_q;
    logic          flowPend_q;
    logic          flowMark_q;
    dpp_pkg::dpp_pads_type pads_q;
    dpp_pkg::dpp_claim_type claim_d;
    logic          mclrActive;
    logic          mclrRise;
    logic          setup;
    logic          access;
    logic          wrEn;
    logic          hit;
    logic          pclk;
    logic          pdata;
    logic          progPins;
    logic          wdtAbort;

    function automatic logic decode(input logic [7:0] a);
        decode = (a == dpp_pkg::OFF_PORTCTRL) || (a == dpp_pkg::OFF_CFG0) ||
                 (a == dpp_pkg::OFF_STATUS) || (a == dpp_pkg::OFF_MASK) ||
                 (a == dpp_pkg::OFF_SESSION);
    endfunction

    // pins are asynchronous, two flops before any use
    always_ff @(posedge mclk) begin
        if (reset) begin
            mclrSync_q <= 2'h0;
            mclrOld_q  <= 1'b0;
            padSync1_q <= '0;
            padSync2_q <= '0;
            pclkOld_q  <= 1'b0;
        end else begin
            mclrSync_q <= {mclrSync_q[0], ~masterClearPinN};
            mclrOld_q  <= mclrSync_q[1];
            padSync1_q <= padIn;
            padSync2_q <= padSync1_q;
            pclkOld_q  <= pclk;
        end
    end

    assign mclrActive = mclrSync_q[1];
    assign mclrRise   = mclrSync_q[1] & ~mclrOld_q;

    // apb decode; slave always ready, unmapped addresses answer with error
    assign setup   = psel & ~penable;
    assign access  = psel & penable;
    assign hit     = decode(paddr);
    assign wrEn    = access & pwrite & hit;
    assign pready  = 1'b1;
    assign pslverr = access & ~hit;
    assign prdata  = prdata_q;

    // read data captured in setup so the status clear matches what was returned
    always_ff @(posedge mclk) begin
        if (reset) begin
            prdata_q <= 32'h0;
        end else if (setup && !pwrite) begin
            case (paddr)
                dpp_pkg::OFF_PORTCTRL: prdata_q <= {28'h0, scanEn_q, traceEn_q, 2'h0};
                dpp_pkg::OFF_CFG0:     prdata_q <= {28'h0, pairSel_q, 1'b0, dbgCfg_q};
                dpp_pkg::OFF_STATUS:   prdata_q <= {28'h0, status_q};
                dpp_pkg::OFF_MASK:     prdata_q <= {28'h0, mask_q};
                dpp_pkg::OFF_SESSION:  prdata_q <= {26'h0, tap_q, serProg_q,
                                                    claim_d.scanClaim, claim_d.traceClaim,
                                                    claim_d.progPri, claim_d.progAlt};
                default:               prdata_q <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            scanEn_q  <= dpp_pkg::SCAN_EN_RST;
            traceEn_q <= dpp_pkg::TRACE_EN_RST;
            pairSel_q <= dpp_pkg::PAIR_SEL_RST;
            dbgCfg_q  <= dpp_pkg::DBG_RST;
            mask_q    <= '0;
        end else if (wrEn) begin
            case (paddr)
                dpp_pkg::OFF_PORTCTRL: begin
                    scanEn_q  <= pwdata[dpp_pkg::BIT_SCAN_EN];
                    traceEn_q <= pwdata[dpp_pkg::BIT_TRACE_EN];
                end
                dpp_pkg::OFF_CFG0: begin
                    pairSel_q <= pwdata[dpp_pkg::BIT_PAIR_SEL];
                    dbgCfg_q  <= pwdata[dpp_pkg::BIT_DBG_LO +: 2];
                end
                dpp_pkg::OFF_MASK: mask_q <= pwdata[NE-1:0];
                default: mask_q <= mask_q;
            endcase
        end
    end

    // serial programming session; no interrupt input reaches it
    always_ff @(posedge mclk) begin
        if (reset) begin
            serProg_q <= 1'b0;
        end else if (serProg_q && mclrRise) begin
            serProg_q <= 1'b0;
        end else if (progEnterReq && mclrActive) begin
            serProg_q <= 1'b1;
        end
    end

    // scan controller choice
    always_ff @(posedge mclk) begin
        if (reset) begin
            tap_q <= dpp_pkg::TAP_VENDOR;
        end else if (mclrActive || watchdogReset) begin
            tap_q <= dpp_pkg::TAP_VENDOR;
        end else if (instrValid && instrCode == dpp_pkg::CMD_SEL_EXT) begin
            tap_q <= dpp_pkg::TAP_EXT;
        end else if (instrValid && instrCode == dpp_pkg::CMD_SEL_VENDOR) begin
            tap_q <= dpp_pkg::TAP_VENDOR;
        end
    end
    assign tapExtended = (tap_q == dpp_pkg::TAP_EXT);

    // erase keeps running; only a programming sequence outside erase is cut
    assign wdtAbort = watchdogReset & flashProgBusy & ~eraseBusy;

    always_ff @(posedge mclk) begin
        if (reset) begin
            progAbort_q <= 1'b0;
        end else begin
            progAbort_q <= wdtAbort;
        end
    end
    assign progAbort = progAbort_q;

    // sticky events; a set in the clearing cycle survives
    always_comb begin
        evtSet = '0;
        evtSet[dpp_pkg::EVT_WDT_ERASE]  = watchdogReset & eraseBusy;
        evtSet[dpp_pkg::EVT_PROG_ABORT] = wdtAbort;
        evtSet[dpp_pkg::EVT_SER_EXIT]   = serProg_q & mclrRise;
        evtSet[dpp_pkg::EVT_DBG_EXIT]   = tapExtended & (mclrActive | watchdogReset);
    end
    assign rdClr = (access && !pwrite && paddr == dpp_pkg::OFF_STATUS) ?
                   prdata_q[NE-1:0] : '0;

    always_ff @(posedge mclk) begin
        if (reset) begin
            status_q <= '0;
            irq_q    <= 1'b0;
        end else begin
            status_q <= (status_q & ~rdClr) | evtSet;
            irq_q    <= |(status_q & mask_q);
        end
    end
    assign irq = irq_q;

    // pin claims
    assign progPins = serProg_q | (dbgCfg_q != dpp_pkg::DBG_OFF);
    always_comb begin
        claim_d.scanClaim  = scanEn_q | mclrActive;
        claim_d.traceClaim = traceEn_q;
        claim_d.progPri    = progPins & pairSel_q;
        claim_d.progAlt    = progPins & ~pairSel_q;
    end
    assign claim = claim_d;

    // serial link: the programming clock is sampled and its rising edges found
    assign pclk  = pairSel_q ? padSync2_q[dpp_pkg::PAD_PCLK1] : padSync2_q[dpp_pkg::PAD_PCLK2];
    assign pdata = pairSel_q ? padSync2_q[dpp_pkg::PAD_PDATA1] : padSync2_q[dpp_pkg::PAD_PDATA2];

    always_ff @(posedge mclk) begin
        if (reset) begin
            progBitValid_q <= 1'b0;
            progBit_q      <= 1'b0;
        end else begin
            progBitValid_q <= progPins & pclk & ~pclkOld_q;
            if (progPins && pclk && !pclkOld_q) begin
                progBit_q <= pdata;
            end
        end
    end
    assign progBitValid = progBitValid_q;
    assign progBit      = progBit_q;

    // trace clock runs at half the trace beat rate from a one-cycle enable
    always_ff @(posedge mclk) begin
        if (reset) begin
            traceTick_q <= 1'b0;
            tclk_q      <= 1'b0;
        end else if (traceEn_q) begin
            traceTick_q <= ~traceTick_q;
            if (traceTick_q) begin
                tclk_q <= ~tclk_q;
            end
        end else begin
            traceTick_q <= 1'b0;
            tclk_q      <= 1'b0;
        end
    end

    // interrupt only adds a marker beat; the trace pacing never pauses
    always_ff @(posedge mclk) begin
        if (reset) begin
            flowPend_q <= 1'b0;
            flowMark_q <= 1'b0;
        end else begin
            flowMark_q <= traceEn_q & traceTick_q & tclk_q & flowPend_q;
            if (!traceEn_q) begin
                flowPend_q <= 1'b0;
            end else if (interruptTaken) begin
                flowPend_q <= 1'b1;
            end else if (traceTick_q && tclk_q) begin
                flowPend_q <= 1'b0;
            end
        end
    end
    assign traceFlowMark = flowMark_q;

    // pad drivers: claimed pins take port values, the rest keep the alternate
    always_ff @(posedge mclk) begin
        if (reset) begin
            pads_q.out <= '0;
            pads_q.oeN <= '1;
        end else begin
            pads_q <= altPads;
            if (claim_d.scanClaim) begin
                pads_q.out[dpp_pkg::PAD_SDO] <= scanDataOut;
                pads_q.oeN[dpp_pkg::PAD_SDO] <= 1'b0;
                pads_q.oeN[dpp_pkg::PAD_SCK] <= 1'b1;
                pads_q.oeN[dpp_pkg::PAD_SDI] <= 1'b1;
                pads_q.oeN[dpp_pkg::PAD_SMS] <= 1'b1;
            end
            if (claim_d.progPri) begin
                pads_q.oeN[dpp_pkg::PAD_PCLK1]  <= 1'b1;
                pads_q.out[dpp_pkg::PAD_PDATA1] <= progDataOut;
                pads_q.oeN[dpp_pkg::PAD_PDATA1] <= ~progDrive;
            end
            if (claim_d.progAlt) begin
                pads_q.oeN[dpp_pkg::PAD_PCLK2]  <= 1'b1;
                pads_q.out[dpp_pkg::PAD_PDATA2] <= progDataOut;
                pads_q.oeN[dpp_pkg::PAD_PDATA2] <= ~progDrive;
            end
            if (claim_d.traceClaim) begin
                pads_q.out[dpp_pkg::PAD_TCLK] <= tclk_q;
                pads_q.oeN[dpp_pkg::PAD_TCLK] <= 1'b0;
                pads_q.out[dpp_pkg::PAD_TD0 +: 4] <= flowPend_q ? dpp_pkg::TRACE_FLOW_CODE : traceWord;
                pads_q.oeN[dpp_pkg::PAD_TD0 +: 4] <= 4'h0;
            end
        end
    end
    assign pads = pads_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_ser_exit_master_clear_pin: assert property (serProg_q && mclrRise |=> !serProg_q)
        else $error("serial programming survived master clear");
    a_ext_exit_master_clear_pin: assert property (mclrActive |=> !tapExtended)
        else $error("extended debug survived master clear");
    a_erase_no_abort: assert property (eraseBusy |=> !progAbort)
        else $error("erase aborted by watchdog");
    a_wdt_flag_set: assert property (watchdogReset && eraseBusy |=> status_q[dpp_pkg::EVT_WDT_ERASE])
        else $error("watchdog flag not set during erase");
    a_wdt_vendor_tap: assert property (tapExtended && watchdogReset |=> !tapExtended)
        else $error("watchdog did not restore vendor controller");
    a_prog_abort: assert property (watchdogReset && flashProgBusy && !eraseBusy |=> progAbort)
        else $error("programming not aborted");
    a_entry_master_clear_pin: assert property ($rose(serProg_q) |-> $past(mclrActive))
        else $error("serial programming entered without master clear");
    a_scan_claim: assert property (mclrActive |-> claim.scanClaim)
        else $error("master clear did not claim scan port");
    a_scan_pin: assert property (!claim.scanClaim |=> pads.oeN[dpp_pkg::PAD_SDO]
                                 == $past(altPads.oeN[dpp_pkg::PAD_SDO]))
        else $error("scan data out driven while unclaimed");
    a_trace_off: assert property (!traceEn_q |=> pads.out[dpp_pkg::PAD_TCLK]
                                  == $past(altPads.out[dpp_pkg::PAD_TCLK]))
        else $error("trace clock driven while disabled");
    a_pair_sel: assert property (progPins |-> claim.progPri == pairSel_q && claim.progAlt != pairSel_q)
        else $error("pin pair selection wrong");
    a_flow_mark: assert property (traceEn_q && interruptTaken |=> flowPend_q [*1] ##[1:4] flowMark_q)
        else $error("flow change not reported");

    c_ser_session: cover property (!serProg_q ##1 serProg_q ##[1:20] !serProg_q);
    c_ext_wdt: cover property (tapExtended && watchdogReset);
    c_status_irq: cover property ($rose(irq));
    c_flow_mark: cover property (flowMark_q);
endmodule
`default_nettype wire

// ---- tb/dpp_prog_model.sv ----
// behavioural programmer and debugger at the far side of the debug pins
`timescale 1ns/1ns
`default_nettype none
module dpp_prog_model (
    input  wire logic       mclk,
    output logic            linkClk,
    output logic            linkData,
    output logic            masterClearPinN,
    output logic            progEnterReq,
    output logic            instrValid,
    output logic [4:0]      instrCode
);
    initial begin
        linkClk = 1'b0;
        linkData = 1'b1;
        masterClearPinN = 1'b1;
        progEnterReq = 1'b0;
        instrValid = 1'b0;
        instrCode = 5'h00;
    end

    // every task is only used while the device is awake
    // link clock stands low between frames; released data line shows the inverse of the last bit
    task automatic send_byte(input logic [7:0] b);
        #7;
        for (int i = 0; i < 8; i++) begin
            linkData = b[7-i];
            #160 linkClk = 1'b1;
            #160 linkClk = 1'b0;
        end
        linkData = ~b[0];
    endtask

    // a scan instruction held for one mclk cycle
    task automatic load_instr(input logic [4:0] c);
        instrValid <= 1'b1;
        instrCode <= c;
        @(posedge mclk);
        instrValid <= 1'b0;
        instrCode <= ~c;
    endtask

    task automatic set_clear(input logic lvl);
        masterClearPinN <= lvl;
    endtask

    task automatic enter_req();
        progEnterReq <= 1'b1;
        @(posedge mclk);
        progEnterReq <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the debug port pin selection block
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic                   mclk, reset, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]             paddr;
    logic [31:0]            pwdata, prdata, q;
    logic                   mclrN, linkClk, linkData, progEnterReq, progBitValid, progBit, instrValid;
    logic [4:0]             instrCode;
    logic                   tapExtended, watchdogReset, eraseBusy, flashProgBusy, progAbort;
    logic                   interruptTaken, traceFlowMark, progDrive, progDataOut, scanDataOut;
    logic [3:0]             traceWord;
    logic [12:0]            padBase, padIn;
    logic [7:0]             b;
    dpp_pkg::dpp_pads_type  pads, altPads;
    dpp_pkg::dpp_claim_type claim;
    logic                   rxq[$];
    int                     error_cnt, compares, seed, abortCnt, flowCnt, n, slvErr;
    int                     scanEn, traceEn, pairSel, dbg, mclrAct;

    assign padIn = (padBase & ~13'h0101) | {4'h0, linkClk, 8'h00} | {12'h000, linkData};

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    dpp_prog_model prog (.mclk(mclk), .linkClk(linkClk), .linkData(linkData), .masterClearPinN(mclrN),
        .progEnterReq(progEnterReq), .instrValid(instrValid), .instrCode(instrCode));

    dpp_port_select DUT (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .masterClearPinN(mclrN), .padIn(padIn), .pads(pads), .altPads(altPads), .claim(claim),
        .progEnterReq(progEnterReq), .progDrive(progDrive), .progDataOut(progDataOut),
        .progBitValid(progBitValid), .progBit(progBit), .scanDataOut(scanDataOut), .instrValid(instrValid),
        .instrCode(instrCode), .tapExtended(tapExtended), .watchdogReset(watchdogReset),
        .eraseBusy(eraseBusy), .flashProgBusy(flashProgBusy), .progAbort(progAbort),
        .interruptTaken(interruptTaken), .traceWord(traceWord), .traceFlowMark(traceFlowMark));

    always @(posedge mclk) begin
        if (progBitValid === 1'b1) rxq.push_back(progBit);
        if (progAbort === 1'b1) abortCnt++;
        if (traceFlowMark === 1'b1) flowCnt++;
        if (pslverr === 1'b1) slvErr++;
    end

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
            error_cnt++;
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
    endtask

    // one apb transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rq);
        int w;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        w = 0;
        while (pready !== 1'b1 && w < 50) begin
            w++;
            @(posedge mclk);
        end
        if (w == 50) begin
            error_cnt++;
            end_of_test();
        end
        rq = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, q);
    endtask

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask

    task automatic pulse_wd();
        watchdogReset <= 1'b1;
        tick(1);
        watchdogReset <= 1'b0;
    endtask

    function automatic logic [31:0] exp_claim();
        return {28'h0, 1'(scanEn | mclrAct), 1'(traceEn), 1'(pairSel == 1 && dbg != 3), 1'(pairSel == 0 && dbg != 3)};
    endfunction

    initial begin
        repeat (100000) @(posedge mclk);
        error_cnt++;
        end_of_test();
    end

    initial begin
        seed = 91570;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {watchdogReset, eraseBusy, flashProgBusy, interruptTaken} = '0;
        progDrive = 1'b0;
        progDataOut = 1'b0;
        scanDataOut = 1'b0;
        traceWord = 4'h0;
        padBase = 13'h0000;
        altPads = '0;
        reset = 1'b1;
        {scanEn, traceEn, pairSel, dbg, mclrAct} = {32'd1, 32'd0, 32'd1, 32'd3, 32'd0};
        tick(5);
        reset <= 1'b0;
        tick(1);
        chk("claimReset", exp_claim(), 32'(claim));
        rd("portCtrl", dpp_pkg::OFF_PORTCTRL, 32'h8);
        rd("cfg0", dpp_pkg::OFF_CFG0, 32'hb);
        rd("session", dpp_pkg::OFF_SESSION, 32'h8);
        apb(1'b0, 8'h14, 32'h0, q);
        chk("unmapped", 32'h0, q);
        chk("slvErr", 32'h1, slvErr);
        // scan pins released back to their ordinary function
        altPads <= 26'($random(seed));
        padBase <= 13'($random(seed));
        {progDrive, progDataOut, scanDataOut} <= 3'($random(seed));
        traceWord <= 4'($random(seed));
        wr(dpp_pkg::OFF_PORTCTRL, 32'h0);
        scanEn = 0;
        tick(2);
        chk("claim", exp_claim(), 32'(claim));
        chk("scanPads", {altPads.out[12:10], altPads.out[2], altPads.oeN[12:10], altPads.oeN[2]},
            {pads.out[12:10], pads.out[2], pads.oeN[12:10], pads.oeN[2]});
        // entry request without master clear is ignored
        prog.enter_req();
        tick(2);
        rd("sessionNoEntry", dpp_pkg::OFF_SESSION, exp_claim());
        prog.set_clear(1'b0);
        tick(4);
        mclrAct = 1;
        chk("scanClaimClear", {2'h2, scanDataOut}, {claim.scanClaim, pads.oeN[2], pads.out[2]});
        prog.enter_req();
        tick(2);
        apb(1'b0, dpp_pkg::OFF_SESSION, 32'h0, q);
        chk("serialOn", 32'h1, 32'(q[4]));
        prog.set_clear(1'b1);
        tick(4);
        mclrAct = 0;
        prog.set_clear(1'b0);
        tick(4);
        apb(1'b0, dpp_pkg::OFF_SESSION, 32'h0, q);
        chk("serialOff", 32'h0, 32'(q[4]));
        prog.set_clear(1'b1);
        tick(4);
        rd("statusSer", dpp_pkg::OFF_STATUS, 32'h4);
        rd("statusClr", dpp_pkg::OFF_STATUS, 32'h0);
        // trace port claim and flow marker
        wr(dpp_pkg::OFF_PORTCTRL, 32'h4);
        traceEn = 1;
        tick(2);
        chk("claimTrace", exp_claim(), 32'(claim));
        chk("traceOe", {traceWord, 5'h0}, {pads.out[7:4], pads.oeN[7:3]});
        n = flowCnt;
        interruptTaken <= 1'b1;
        tick(1);
        interruptTaken <= 1'b0;
        tick(10);
        chk("flowMark", n + 1, flowCnt);
        chk("claimIrq", exp_claim(), 32'(claim));
        wr(dpp_pkg::OFF_PORTCTRL, 32'h0);
        traceEn = 0;
        tick(2);
        chk("tracePads", {altPads.out[7:3], altPads.oeN[7:3]}, {pads.out[7:3], pads.oeN[7:3]});
        // every pair select and debug field setting
        for (int i = 0; i < 8; i++) begin
            wr(dpp_pkg::OFF_CFG0, {28'h0, i[2], 1'b0, i[1:0]});
            pairSel = i / 4;
            dbg = i % 4;
            tick(2);
            chk("claimProg", exp_claim(), 32'(claim));
        end
        // serial bits over the primary clock pin
        wr(dpp_pkg::OFF_CFG0, 32'h8);
        pairSel = 1;
        dbg = 0;
        rxq.delete();
        b = 8'($random(seed));
        prog.send_byte(b);
        n = 0;
        while (rxq.size() < 8 && n < 40) begin
            n++;
            tick(1);
        end
        chk("rxCount", 32'd8, rxq.size());
        for (int i = 0; i < 8 && i < rxq.size(); i++) chk("progBit", 32'(b[7-i]), 32'(rxq[i]));
        chk("progPad", {~progDrive, progDataOut}, {pads.oeN[0], pads.out[0]});
        // scan controller selection
        prog.load_instr(dpp_pkg::CMD_SEL_EXT);
        tick(2);
        chk("tapExt", 32'h1, 32'(tapExtended));
        prog.load_instr(dpp_pkg::CMD_SEL_VENDOR);
        tick(2);
        chk("tapVendor", 32'h0, 32'(tapExtended));
        prog.load_instr(dpp_pkg::CMD_SEL_EXT);
        tick(2);
        pulse_wd();
        tick(2);
        chk("tapWd", 32'h0, 32'(tapExtended));
        prog.load_instr(dpp_pkg::CMD_SEL_EXT);
        tick(2);
        prog.set_clear(1'b0);
        tick(4);
        chk("tapClear", 32'h0, 32'(tapExtended));
        prog.set_clear(1'b1);
        tick(4);
        rd("statusDbg", dpp_pkg::OFF_STATUS, 32'h8);
        // watchdog during erase, then during programming
        eraseBusy <= 1'b1;
        n = abortCnt;
        pulse_wd();
        tick(4);
        chk("noAbort", n, abortCnt);
        rd("statusErase", dpp_pkg::OFF_STATUS, 32'h1);
        eraseBusy <= 1'b0;
        flashProgBusy <= 1'b1;
        pulse_wd();
        tick(4);
        chk("abort", n + 1, abortCnt);
        rd("statusAbort", dpp_pkg::OFF_STATUS, 32'h2);
        flashProgBusy <= 1'b0;
        // interrupt: set mask bits let their events through
        wr(dpp_pkg::OFF_MASK, 32'h1);
        rd("mask", dpp_pkg::OFF_MASK, 32'h1);
        eraseBusy <= 1'b1;
        pulse_wd();
        tick(3);
        chk("irqOn", 32'h1, 32'(irq));
        rd("statusIrq", dpp_pkg::OFF_STATUS, 32'h1);
        tick(2);
        chk("irqOff", 32'h0, 32'(irq));
        wr(dpp_pkg::OFF_MASK, 32'h0);
        pulse_wd();
        tick(3);
        chk("irqMasked", 32'h0, 32'(irq));
        rd("statusMasked", dpp_pkg::OFF_STATUS, 32'h1);
        for (int i = 0; i < 4; i++) begin
            n = abortCnt;
            {eraseBusy, flashProgBusy} <= 2'($random(seed));
            pulse_wd();
            tick(3);
            chk("abortRnd", n + (flashProgBusy & ~eraseBusy), abortCnt);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
